// file: hw/sff_defs.svh
// Constants of the serial flash pin front end
`ifndef SFF_DEFS_SVH
`define SFF_DEFS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SFF_PAGES 4096
`define SFF_PAGE_AW 12
`define SFF_BUF_BYTES 264
`define SFF_LAST_STD 9'h107
`define SFF_LAST_BIN 9'h0FF
`define SFF_SECTORS 16
`define SFF_SEC_MSB 11
`define SFF_SEC_LSB 8

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SFF_OP_BUF1_WR 8'h10
`define SFF_OP_BUF2_WR 8'h11
`define SFF_OP_BUF1_RD 8'h20
`define SFF_OP_BUF2_RD 8'h21
`define SFF_OP_BUF1_PROG 8'h30
`define SFF_OP_BUF2_PROG 8'h31
`define SFF_OP_PAGE_ERASE 8'h40
`define SFF_OP_XFER1 8'h50
`define SFF_OP_XFER2 8'h51
`define SFF_OP_PROT_EN 8'h60
`define SFF_OP_PROT_DIS 8'h61
`define SFF_OP_PROT_WR 8'h62
`define SFF_OP_PROT_CLR 8'h63
`define SFF_OP_LOCKDOWN 8'h64
`define SFF_OP_STATUS 8'h70

// ----------------------------------------------------------------
// Frame byte positions
// ----------------------------------------------------------------
`define SFF_BYTE_OPC 3'h0
`define SFF_BYTE_ADDR_LAST 3'h3
`define SFF_BYTE_DATA 3'h4
`define SFF_BYTE_MASK_DONE 3'h3
`define SFF_BYTE_SAT 3'h7

// ----------------------------------------------------------------
// Array request codes
// ----------------------------------------------------------------
`define SFF_AOP_PROG 2'h0
`define SFF_AOP_ERASE 2'h1
`define SFF_AOP_READ 2'h2

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define SFF_ST_READY 7
`define SFF_ST_PROT_EN 6
`define SFF_ST_WP_LOW 5
`define SFF_ST_PAGE_BIN 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFF_CLK_NS 50
`define SFF_T_PROG_NS 2000000
`define SFF_T_ERASE_NS 4000000

`endif

// file: hw/sff_pkg.sv
// Types of the serial flash pin front end
`include "sff_defs.svh"

package sff_pkg;

	// ------------------------------------------------------------
	// Self-timed engine states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		E_IDLE,
		E_REQ,
		E_STREAM,
		E_FILL,
		E_TIME
	} sff_estate_t;

	// ------------------------------------------------------------
	// Whole state of the front end except the program data FIFO, which sff_fifo holds
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sck_q;
		logic [2:0] csn_q;
		logic [1:0] si_q;
		logic [1:0] wpn_q;
		logic [1:0] rpn_q;
		logic [7:0] opc;
		logic [6:0] sh;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [23:0] addr;
		logic [8:0] bptr;
		logic [7:0] osh;
		logic [7:0] obyte;
		logic oload;
		logic oen;
		logic so;
		logic [`SFF_SECTORS-1:0] prot;
		logic [`SFF_SECTORS-1:0] lock;
		logic prot_en;
		sff_estate_t est;
		logic [1:0] eop;
		logic ebuf;
		logic [`SFF_PAGE_AW-1:0] epage;
		logic [8:0] eidx;
		logic [23:0] etimer;
		logic [1:0][`SFF_BUF_BYTES-1:0][7:0] buff;
	} sff_state_t;

endpackage

// file: hw/sff_fifo.sv
// Small synchronous FIFO in flip-flops
`timescale 1ns/10ps

module sff_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	// Depth must be a power of two for the pointer wrap
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} sff_fifo_st_t;

	sff_fifo_st_t s_r;
	sff_fifo_st_t s_nxt;
	logic [AW:0] count;

	assign count = s_r.wptr - s_r.rptr;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = s_r.wptr != s_r.rptr;
	assign out_data = s_r.mem[s_r.rptr[AW-1:0]];

	always_comb begin
		s_nxt = s_r;
		if (in_valid && in_ready) begin
			s_nxt.mem[s_r.wptr[AW-1:0]] = in_data;
			s_nxt.wptr = s_r.wptr + (AW+1)'(1);
		end
		if (out_valid && out_ready) begin
			s_nxt.rptr = s_r.rptr + (AW+1)'(1);
		end
		if (flush) begin
			s_nxt.wptr = '0;
			s_nxt.rptr = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

endmodule

// file: hw/sff_front.sv
// Serial flash pin front end: framing, protection, reset, buffers
`timescale 1ns/10ps
`include "sff_defs.svh"

module sff_front #(
	parameter int unsigned PROG_NS = `SFF_T_PROG_NS,
	parameter int unsigned ERASE_NS = `SFF_T_ERASE_NS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// Serial pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Control pins
	input wire logic wp_n,
	input wire logic reset_pin_n,
	// Configuration
	input wire logic cfg_page_bin,
	// Status
	output logic standby,
	output logic busy,
	// Array request
	output logic arr_valid,
	input wire logic arr_ready,
	output logic [1:0] arr_op,
	output logic [`SFF_PAGE_AW-1:0] arr_page,
	output logic arr_abort,
	// Array program data
	output logic arr_wvalid,
	input wire logic arr_wready,
	output logic [7:0] arr_wdata,
	// Array read data
	input wire logic arr_rvalid,
	input wire logic [7:0] arr_rdata
);

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam int unsigned PROG_CYC_I =
		(PROG_NS + `SFF_CLK_NS - 1) / `SFF_CLK_NS;
	localparam int unsigned ERASE_CYC_I =
		(ERASE_NS + `SFF_CLK_NS - 1) / `SFF_CLK_NS;
	localparam logic [23:0] PROG_CYC = 24'(PROG_CYC_I);
	localparam logic [23:0] ERASE_CYC = 24'(ERASE_CYC_I);

	// ------------------------------------------------------------
	// State and helpers
	// ------------------------------------------------------------
	sff_pkg::sff_state_t s_r;
	sff_pkg::sff_state_t s_nxt;

	logic rise;
	logic fall;
	logic sel;
	logic cs_fall;
	logic cs_rise;
	logic wp_low;
	logic rpin_low;
	logic eng_busy;
	logic [7:0] inbyte;
	logic [7:0] op;
	logic [8:0] last_idx;
	logic [`SFF_PAGE_AW-1:0] page;
	logic [3:0] sec;
	logic blocked;
	logic aligned;
	logic [7:0] status;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic fifo_flush;

	function automatic logic [8:0] bump(input logic [8:0] p,
		input logic [8:0] last);
		bump = (p == last) ? 9'h000 : p + 9'h001;
	endfunction

	// ------------------------------------------------------------
	// Program data path towards the array
	// ------------------------------------------------------------
	// The array can stall the stream; the engine waits on in_ready
	sff_fifo #(
		.WIDTH(8),
		.DEPTH(16)
	) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(arr_wvalid),
		.out_ready(arr_wready),
		.out_data(arr_wdata)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Edge detectors look only at second and third stages
		rise = s_r.sck_q[1] & ~s_r.sck_q[2];
		fall = ~s_r.sck_q[1] & s_r.sck_q[2];
		sel = ~s_r.csn_q[1];
		cs_fall = ~s_r.csn_q[1] & s_r.csn_q[2];
		cs_rise = s_r.csn_q[1] & ~s_r.csn_q[2];
		wp_low = ~s_r.wpn_q[1];
		rpin_low = ~s_r.rpn_q[1];
		eng_busy = s_r.est != sff_pkg::E_IDLE;
		inbyte = {s_r.sh, s_r.si_q[1]};
		op = (s_r.byte_cnt == `SFF_BYTE_OPC) ? inbyte : s_r.opc;
		last_idx = cfg_page_bin ? `SFF_LAST_BIN : `SFF_LAST_STD;
		page = cfg_page_bin ? s_r.addr[19:8] : s_r.addr[20:9];
		sec = page[`SFF_SEC_MSB:`SFF_SEC_LSB];
		blocked = s_r.lock[sec] |
			(s_r.prot[sec] & (s_r.prot_en | wp_low));
		aligned = s_r.bit_cnt == 3'h0;
		status = 8'h00;
		status[`SFF_ST_READY] = ~eng_busy;
		status[`SFF_ST_PROT_EN] = s_r.prot_en;
		status[`SFF_ST_WP_LOW] = wp_low;
		status[`SFF_ST_PAGE_BIN] = cfg_page_bin;
		fifo_in_valid = 1'b0;
		fifo_in_data = s_r.buff[s_r.ebuf][s_r.eidx];
		fifo_flush = 1'b0;

		// Pin synchronisers
		s_nxt.sck_q = {s_r.sck_q[1:0], sck};
		s_nxt.csn_q = {s_r.csn_q[1:0], cs_n};
		s_nxt.si_q = {s_r.si_q[0], si};
		s_nxt.wpn_q = {s_r.wpn_q[0], wp_n};
		s_nxt.rpn_q = {s_r.rpn_q[0], reset_pin_n};

		// --------------------------------------------------------
		// Frame decode
		// --------------------------------------------------------
		if (cs_fall) begin
			s_nxt.bit_cnt = 3'h0;
			s_nxt.byte_cnt = 3'h0;
			s_nxt.oen = 1'b0;
			s_nxt.oload = 1'b0;
		end else if (sel && rise) begin
			s_nxt.sh = inbyte[6:0];
			s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
			if (s_r.bit_cnt == 3'h7) begin
				if (s_r.byte_cnt != `SFF_BYTE_SAT) begin
					s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
				end
				if (s_r.byte_cnt == `SFF_BYTE_OPC) begin
					s_nxt.opc = inbyte;
				end else if (s_r.byte_cnt <= `SFF_BYTE_ADDR_LAST) begin
					s_nxt.addr = {s_r.addr[15:0], inbyte};
				end
				if (s_r.byte_cnt == `SFF_BYTE_ADDR_LAST) begin
					s_nxt.bptr = cfg_page_bin ? {1'b0, inbyte} :
						{s_r.addr[0], inbyte};
				end
				// Buffer being programmed refuses writes to stay coherent
				if ((op == `SFF_OP_BUF1_WR || op == `SFF_OP_BUF2_WR) &&
					s_r.byte_cnt >= `SFF_BYTE_DATA &&
					!(eng_busy && s_r.ebuf == op[0])) begin
					s_nxt.buff[op[0]][s_r.bptr] = inbyte;
					s_nxt.bptr = bump(s_r.bptr, last_idx);
				end
				if (op == `SFF_OP_STATUS) begin
					s_nxt.obyte = status;
					s_nxt.oload = 1'b1;
					s_nxt.oen = 1'b1;
				end else if ((op == `SFF_OP_BUF1_RD ||
					op == `SFF_OP_BUF2_RD) &&
					s_r.byte_cnt >= `SFF_BYTE_DATA) begin
					s_nxt.obyte = s_r.buff[op[0]][s_r.bptr];
					s_nxt.bptr = bump(s_r.bptr, last_idx);
					s_nxt.oload = 1'b1;
					s_nxt.oen = 1'b1;
				end
			end
		end

		// Output moves on the falling edge, which suits modes 0 and 3
		if (sel && fall && s_r.oen) begin
			if (s_r.oload) begin
				s_nxt.so = s_r.obyte[7];
				s_nxt.osh = {s_r.obyte[6:0], 1'b0};
				s_nxt.oload = 1'b0;
			end else begin
				s_nxt.so = s_r.osh[7];
				s_nxt.osh = {s_r.osh[6:0], 1'b0};
			end
		end

		// --------------------------------------------------------
		// Execute at deselect
		// --------------------------------------------------------
		if (cs_rise) begin
			s_nxt.oen = 1'b0;
			s_nxt.oload = 1'b0;
			if (aligned) begin
				case (s_r.opc)
					`SFF_OP_BUF1_PROG,
					`SFF_OP_BUF2_PROG,
					`SFF_OP_PAGE_ERASE: begin
						if (s_r.byte_cnt >= `SFF_BYTE_DATA && !eng_busy &&
							!wp_low && !blocked) begin
							s_nxt.est = sff_pkg::E_REQ;
							s_nxt.eop = (s_r.opc == `SFF_OP_PAGE_ERASE) ?
								`SFF_AOP_ERASE : `SFF_AOP_PROG;
							s_nxt.etimer =
								(s_r.opc == `SFF_OP_PAGE_ERASE) ?
								ERASE_CYC : PROG_CYC;
							s_nxt.ebuf = s_r.opc[0];
							s_nxt.epage = page;
							s_nxt.eidx = 9'h000;
						end
					end
					`SFF_OP_XFER1,
					`SFF_OP_XFER2: begin
						if (s_r.byte_cnt >= `SFF_BYTE_DATA &&
							!eng_busy) begin
							s_nxt.est = sff_pkg::E_REQ;
							s_nxt.eop = `SFF_AOP_READ;
							s_nxt.etimer = 24'h000000;
							s_nxt.ebuf = s_r.opc[0];
							s_nxt.epage = page;
							s_nxt.eidx = 9'h000;
						end
					end
					`SFF_OP_PROT_EN: begin
						if (s_r.byte_cnt != `SFF_BYTE_OPC) begin
							s_nxt.prot_en = 1'b1;
						end
					end
					`SFF_OP_PROT_DIS: begin
						if (s_r.byte_cnt != `SFF_BYTE_OPC && !wp_low) begin
							s_nxt.prot_en = 1'b0;
						end
					end
					`SFF_OP_PROT_WR: begin
						if (s_r.byte_cnt >= `SFF_BYTE_MASK_DONE &&
							!wp_low) begin
							s_nxt.prot = s_r.addr[15:0];
						end
					end
					`SFF_OP_PROT_CLR: begin
						if (s_r.byte_cnt != `SFF_BYTE_OPC && !wp_low) begin
							s_nxt.prot = '0;
						end
					end
					`SFF_OP_LOCKDOWN: begin
						if (s_r.byte_cnt >= `SFF_BYTE_DATA) begin
							s_nxt.lock[sec] = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end

		// --------------------------------------------------------
		// Self-timed engine, independent of chip select
		// --------------------------------------------------------
		case (s_r.est)
			sff_pkg::E_IDLE: begin
			end
			sff_pkg::E_REQ: begin
				if (arr_ready) begin
					if (s_r.eop == `SFF_AOP_PROG) begin
						s_nxt.est = sff_pkg::E_STREAM;
					end else if (s_r.eop == `SFF_AOP_READ) begin
						s_nxt.est = sff_pkg::E_FILL;
					end else begin
						s_nxt.est = sff_pkg::E_TIME;
					end
				end
			end
			sff_pkg::E_STREAM: begin
				fifo_in_valid = 1'b1;
				if (fifo_in_ready) begin
					if (s_r.eidx == last_idx) begin
						s_nxt.est = sff_pkg::E_TIME;
					end else begin
						s_nxt.eidx = s_r.eidx + 9'h001;
					end
				end
			end
			sff_pkg::E_FILL: begin
				if (arr_rvalid) begin
					s_nxt.buff[s_r.ebuf][s_r.eidx] = arr_rdata;
					if (s_r.eidx == last_idx) begin
						s_nxt.est = sff_pkg::E_IDLE;
					end else begin
						s_nxt.eidx = s_r.eidx + 9'h001;
					end
				end
			end
			sff_pkg::E_TIME: begin
				// Done only once the timer ran out and the data drained
				if (s_r.etimer != 24'h000000) begin
					s_nxt.etimer = s_r.etimer - 24'h000001;
				end else if (!arr_wvalid) begin
					s_nxt.est = sff_pkg::E_IDLE;
				end
			end
			default: begin
				s_nxt.est = sff_pkg::E_IDLE;
			end
		endcase

		// --------------------------------------------------------
		// Reset pin idles the engine, clears frame counters, opcode and output enable, and flushes the FIFO
		// --------------------------------------------------------
		if (rpin_low) begin
			s_nxt.est = sff_pkg::E_IDLE;
			s_nxt.bit_cnt = 3'h0;
			s_nxt.byte_cnt = 3'h0;
			s_nxt.opc = 8'h00;
			s_nxt.oen = 1'b0;
			s_nxt.oload = 1'b0;
			fifo_flush = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Pin synchronisers of active-low controls reset to deasserted
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.csn_q <= 3'h7;
			s_r.wpn_q <= 2'h3;
			s_r.rpn_q <= 2'h3;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign so = s_r.so;
	assign so_oe = ~s_r.csn_q[1] & s_r.oen;
	assign busy = s_r.est != sff_pkg::E_IDLE;
	assign standby = s_r.csn_q[1] & (s_r.est == sff_pkg::E_IDLE);
	assign arr_valid = s_r.est == sff_pkg::E_REQ;
	assign arr_op = s_r.eop;
	assign arr_page = s_r.epage;
	assign arr_abort = ~s_r.rpn_q[1];

endmodule

// file: dv/sff_front_checker.sv
// Assertion checker for the serial flash pin front end
`timescale 1ns/10ps
`include "sff_defs.svh"

module sff_front_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Serial pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic so,
	input wire logic so_oe,
	// Control pins
	input wire logic wp_n,
	input wire logic reset_pin_n,
	// Status
	input wire logic standby,
	input wire logic busy,
	// Array side
	input wire logic arr_valid,
	input wire logic arr_ready,
	input wire logic [1:0] arr_op,
	input wire logic [`SFF_PAGE_AW-1:0] arr_page,
	input wire logic arr_abort,
	input wire logic arr_wvalid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// --------------------------------------------------------
	// Pin levels held long enough to pass the synchronisers
	// --------------------------------------------------------
	sequence desel;
		cs_n [*5];
	endsequence
	sequence pin_low;
		!reset_pin_n [*5];
	endsequence
	sequence wp_held;
		!wp_n [*5];
	endsequence

	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	chk_oe_desel: assert property (desel |-> !so_oe)
		else $error("serial output driven while deselected");
	chk_so_after_fall: assert property (
		so_oe && $past(so_oe) && !$stable(so) |-> !sck)
		else $error("serial output changed while clock high");
	chk_standby_idle: assert property (desel ##0 !busy |-> standby)
		else $error("no standby while deselected and idle");
	chk_busy_nostby: assert property (busy |-> !standby)
		else $error("standby while an operation runs");
	chk_req_hold: assert property (arr_valid && !arr_ready |=>
		(arr_valid && $stable(arr_op) && $stable(arr_page)) || arr_abort)
		else $error("array request dropped or changed before taken");
	chk_idle_empty: assert property ($fell(busy) |-> !arr_wvalid)
		else $error("engine idle with program data pending");
	chk_req_after_cs: assert property ($rose(arr_valid) |-> $past(cs_n, 3))
		else $error("array request without chip select rising");
	chk_wp_block: assert property (
		wp_held ##0 $rose(arr_valid) |-> arr_op == `SFF_AOP_READ)
		else $error("program or erase issued under write protect");
	chk_pin_abort: assert property (pin_low |-> arr_abort && !busy)
		else $error("reset pin did not abort the engine");
	chk_reset_hold: assert property (
		pin_low ##1 !reset_pin_n |-> !arr_valid && !arr_wvalid && !so_oe)
		else $error("activity while reset pin held low");
endmodule

bind sff_front sff_front_checker u_chk (
	.clk_sys(clk_sys), .rstn(rstn), .sck(sck), .cs_n(cs_n), .so(so),
	.so_oe(so_oe), .wp_n(wp_n), .reset_pin_n(reset_pin_n),
	.standby(standby), .busy(busy), .arr_valid(arr_valid),
	.arr_ready(arr_ready), .arr_op(arr_op), .arr_page(arr_page),
	.arr_abort(arr_abort), .arr_wvalid(arr_wvalid)
);

// file: dv/sff_host.sv
// Host model driving the serial pins in clock mode 0
`timescale 1ns/10ps

module sff_host (
	// Clock
	input wire logic clk_sys,
	// Serial pins
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic [7:0] rxq[$];

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Released data line toggles, so a stale bit is never taken as valid
	always @(posedge clk_sys) begin
		if (cs_n) begin
			si <= ~si;
		end
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Sends nbit bits of tx, then clocks nrd bytes back from the device
	task automatic frame(input logic [7:0] tx[$], input int nbit,
		input int nrd);
		logic [7:0] b;
		logic [7:0] r;
		rxq = {};
		wt(1);
		cs_n = 1'b0;
		wt(4);
		for (int i = 0; i < nbit + 8 * nrd; i++) begin
			b = (i < nbit) ? tx[i / 8] : 8'(~i);
			si = b[7 - i % 8];
			wt(6);
			if (i >= nbit) begin
				r = {r[6:0], so};
				if ((i - nbit) % 8 == 7) begin
					rxq.push_back(r);
				end
			end
			sck = 1'b1;
			wt(5);
			sck = 1'b0;
		end
		wt(4);
		cs_n = 1'b1;
		wt(8);
	endtask
endmodule

// file: dv/tb_top.sv
// Self-checking testbench of the serial flash pin front end
`timescale 1ns/10ps
`include "sff_defs.svh"

module tb_top;
	logic clk_sys, rstn, ce, wp_n, reset_pin_n, cfg_page_bin;
	logic sck, cs_n, si, so, so_oe, standby, busy, arr_valid, arr_ready;
	logic arr_abort, arr_wvalid, arr_wready, arr_rvalid;
	logic [1:0] arr_op, req_op;
	logic [11:0] arr_page, req_pg, pg;
	logic [7:0] arr_wdata, arr_rdata;
	logic [7:0] wq[$];
	logic [7:0] bufm[2][256];
	int n_mismatch = 0;
	int n_tests = 0;
	int n_req = 0;
	int req_base, n_fill;

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Long program time so a buffer can be filled while the other programs
	sff_front #(.PROG_NS(40000), .ERASE_NS(20000)) uut (
		.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .sck(sck), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
		.reset_pin_n(reset_pin_n), .cfg_page_bin(cfg_page_bin),
		.standby(standby), .busy(busy), .arr_valid(arr_valid),
		.arr_ready(arr_ready), .arr_op(arr_op), .arr_page(arr_page),
		.arr_abort(arr_abort), .arr_wvalid(arr_wvalid),
		.arr_wready(arr_wready), .arr_wdata(arr_wdata),
		.arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata));
	sff_host u_host (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe));

	// --------------------------------------------------------
	// Array model with random stalls
	// --------------------------------------------------------
	always @(posedge clk_sys) begin
		if (arr_rvalid) n_fill--;
		if (arr_valid && arr_ready) begin
			n_req++;
			req_op = arr_op;
			req_pg = arr_page;
			if (arr_op == `SFF_AOP_READ) n_fill = cfg_page_bin ? 256 : 264;
		end
		if (arr_wvalid && arr_wready) wq.push_back(arr_wdata);
		#1;
		arr_ready = 1'($urandom);
		arr_wready = ($urandom % 4) != 0;
		arr_rvalid = n_fill > 0 && 1'($urandom);
		arr_rdata = arr_rvalid ? pat(req_pg, (cfg_page_bin ? 256 : 264) -
			n_fill) : 8'($urandom);
	end

	function automatic logic [7:0] pat(input logic [11:0] p, input int i);
		return p[7:0] ^ 8'(i) ^ 8'h5A;
	endfunction

	function automatic logic [7:0] st(input logic pe, input logic wpl);
		return {1'b1, pe, wpl, cfg_page_bin, 4'h0};
	endfunction

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task automatic status(input logic [7:0] e);
		u_host.frame('{`SFF_OP_STATUS}, 8, 2);
		cmp(u_host.rxq[0], e);
		cmp(u_host.rxq[1], e);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [11:0] p,
		input logic acc);
		logic [23:0] ad;
		req_base = n_req;
		// Page field sits one bit higher with the longer page
		ad = cfg_page_bin ? {4'h0, p, 8'h00} : {3'h0, p, 9'h000};
		u_host.frame('{op, ad[23:16], ad[15:8], ad[7:0]}, 32, 0);
		cmp(busy, acc);
	endtask

	task automatic done(input logic acc);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) u_host.wt(1);
		cmp(busy, 1'b0);
		cmp(16'(n_req - req_base), 16'(acc));
	endtask

	task automatic buf_wr(input logic b, input logic [7:0] a, input int n);
		logic [7:0] tx[$];
		tx = '{`SFF_OP_BUF1_WR + 8'(b), 8'h00, 8'h00, a};
		for (int i = 0; i < n; i++) begin
			bufm[b][8'(a + i)] = 8'($urandom);
			tx.push_back(bufm[b][8'(a + i)]);
		end
		u_host.frame(tx, 8 * tx.size(), 0);
	endtask

	task automatic buf_rd(input logic b, input logic [7:0] a, input int n);
		u_host.frame('{`SFF_OP_BUF1_RD + 8'(b), 8'h00, 8'h00, a, 8'h00},
			40, n);
		for (int i = 0; i < n; i++) cmp(u_host.rxq[i], bufm[b][8'(a + i)]);
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		end_of_test();
	end

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		logic [7:0] a;
		int n;
		void'($urandom(32'h8E3566DF));
		{rstn, arr_ready, arr_wready, arr_rvalid, n_fill} = '0;
		{ce, wp_n, reset_pin_n, cfg_page_bin} = 4'hF;
		arr_rdata = 8'h00;
		repeat (20) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		u_host.wt(5);
		status(st(1'b0, 1'b0));
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 8'hFC : 8'($urandom);
			n = $urandom_range(12, 1);
			u_host.frame('{8'hFF}, 5, 0);
			buf_wr(k[0], a, n);
			buf_rd(k[0], a, n);
		end
		u_host.frame('{`SFF_OP_BUF1_PROG, 8'h00, 8'h12}, 24, 0);
		cmp(busy, 1'b0);
		// Read-modify-write of one random page
		pg = {4'h2, 8'($urandom)};
		cmd(`SFF_OP_XFER1, pg, 1'b1);
		done(1'b1);
		cmp(req_op, `SFF_AOP_READ);
		for (int i = 0; i < 256; i++) bufm[0][i] = pat(pg, i);
		buf_wr(1'b0, 8'h40, 3);
		buf_rd(1'b0, 8'h3E, 8);
		wq.delete();
		cmd(`SFF_OP_BUF1_PROG, pg, 1'b1);
		buf_wr(1'b1, 8'h00, 4);
		buf_rd(1'b1, 8'h00, 4);
		done(1'b1);
		cmp(req_pg, pg);
		cmp(req_op, `SFF_AOP_PROG);
		cmp(16'(wq.size()), 16'h0100);
		for (int i = 0; i < 256; i++) cmp(wq[i], bufm[0][i]);
		// Write protect low: array work refused, some commands kept
		wp_n = ~wp_n;
		u_host.wt(4);
		status(st(1'b0, 1'b1));
		cmd(`SFF_OP_BUF2_PROG, 12'h500, 1'b0);
		done(1'b0);
		cmd(`SFF_OP_PAGE_ERASE, 12'h501, 1'b0);
		u_host.frame('{`SFF_OP_PROT_WR, 8'hFF, 8'hFF}, 24, 0);
		u_host.frame('{`SFF_OP_PROT_EN}, 8, 0);
		u_host.frame('{`SFF_OP_PROT_DIS}, 8, 0);
		cmd(`SFF_OP_LOCKDOWN, 12'h3A0, 1'b0);
		status(st(1'b1, 1'b1));
		wp_n = ~wp_n;
		u_host.wt(4);
		status(st(1'b1, 1'b0));
		cmd(`SFF_OP_PAGE_ERASE, 12'h501, 1'b1);
		// Clock enable stalls, then a freeze longer than the erase time
		repeat (100) begin
			ce = ($urandom % 4) != 0;
			u_host.wt(1);
		end
		ce = 1'b0;
		u_host.wt(500);
		cmp(busy, 1'b1);
		ce = 1'b1;
		done(1'b1);
		cmd(`SFF_OP_BUF2_PROG, 12'h3A0, 1'b0);
		// Reset pin in mid-erase
		cmd(`SFF_OP_PAGE_ERASE, 12'h502, 1'b1);
		reset_pin_n = 1'b0;
		u_host.wt(6);
		cmp(busy, 1'b0);
		cmp(arr_abort, 1'b1);
		reset_pin_n = 1'b1;
		u_host.wt(6);
		status(st(1'b1, 1'b0));
		// Longer page: fill runs to its last byte, read wraps after it
		cfg_page_bin = ~cfg_page_bin;
		status(st(1'b1, 1'b0));
		pg = {4'h6, 8'($urandom)};
		cmd(`SFF_OP_XFER2, pg, 1'b1);
		done(1'b1);
		cmp(req_pg, pg);
		u_host.frame('{`SFF_OP_BUF2_RD, 8'h00, 8'h01, 8'h00, 8'h00},
			40, 10);
		for (int i = 0; i < 10; i++) begin
			cmp(u_host.rxq[i], pat(pg, (256 + i) % 264));
		end
		end_of_test();
	end
endmodule
